// >>> spcr_consts.vh
// Purpose: Constants for the switch port control register bank
// Assumes: Included by the bank top, the ingress evaluator and the testbench, not by the field register
// Notes: Byte address is four times the register index
// Functional notes
// - Ingress VLAN filter drops frames whose VLAN membership lacks this port
// - Drop-non-default-VLAN drops frames whose VLAN id differs from default
// - Force flow control overrides the negotiated flow control result
// - Back pressure bit enables half-duplex back pressure
// - Transmit enable, set at reset, gates all transmission
// - Receive enable, set at reset, gates all reception
// - Learning disable stops source address learning from this port
// - Mirror destination bit makes this port transmit monitored frames
// - Receive mirror marks received frames monitored and copies them
// - Transmit mirror marks transmitted frames monitored and copies them
// - Priority ceiling clamps frame priority to default tag priority
// - Membership mask, reset all ones, limits forwarding targets
// - Default tag holds priority, CFI and VLAN id resetting to one
// - Default tag used for untagged or null-id frames and lookup
// - Ingress limit mode selects which frames count toward rate limit
// - Gap counting adds twelve bytes per frame to rate accounting
// - Preamble counting adds eight bytes per frame to rate accounting
// - Inserted egress tag is the ingress port's default tag
`ifndef SPCR_CONSTS_VH
`define SPCR_CONSTS_VH

`define SPCR_IDX_CTRL2 10'h06e
`define SPCR_IDX_DTAG 10'h070
`define SPCR_IDX_CTRL3 10'h072
`define SPCR_ADDR_STAT 12'h3c0

`define SPCR_CTRL2_RST 16'h0607
`define SPCR_CTRL2_MASK 16'h7fef
`define SPCR_DTAG_RST 16'h0001
`define SPCR_DTAG_MASK 16'hffff
`define SPCR_CTRL3_RST 16'h0000
`define SPCR_CTRL3_MASK 16'h000f

`define SPCR_B_VFILT 14
`define SPCR_B_NPVID 13
`define SPCR_B_FFC 12
`define SPCR_B_BP 11
`define SPCR_B_TXEN 10
`define SPCR_B_RXEN 9
`define SPCR_B_LDIS 8
`define SPCR_B_SNIFP 7
`define SPCR_B_RXSN 6
`define SPCR_B_TXSN 5
`define SPCR_B_CEIL 3
`define SPCR_B_PRE 0
`define SPCR_B_IFG 1

`define SPCR_M_ALL 2'b00
`define SPCR_M_BMF 2'b01
`define SPCR_M_BM 2'b10
`define SPCR_M_B 2'b11

`define SPCR_IFG_BYTES 12'h00c
`define SPCR_PRE_BYTES 12'h008

`define SPCR_RESP_OK 2'b00
`define SPCR_RESP_ERR 2'b10

`endif

// >>> spcr_field.v
// Purpose: One 16-bit software register with masked byte writes
// Assumes: Write pulse and data come from the bus slave
// Notes: Bits outside the mask hold zero
`timescale 1ns/1ps
module spcr_field #(
    parameter [15:0] RST = 16'h0000,
    parameter [15:0] MASK = 16'hffff
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire wr_i,
    input wire [15:0] wdata_i,
    input wire [1:0] wstrb_i,
    output wire [15:0] q_o
);
    // ======================================
    // Storage
    reg [15:0] val_q;
    wire [15:0] be = {{8{wstrb_i[1]}}, {8{wstrb_i[0]}}};
    wire [15:0] val_d = ((val_q & ~be) | (wdata_i & be)) & MASK;
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            val_q <= RST & MASK;
        end else if (ce_i && wr_i) begin
            val_q <= val_d;
        end
    end
    assign q_o = val_q;
endmodule // spcr_field

// >>> spcr_port_chk.sv
// Purpose: Port checks for the port control bank
// Assumes: Sees only top module ports
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
module spcr_port_chk (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire an_flow_ctrl_i,
    input wire rx_valid_i,
    input wire [10:0] rx_len_i,
    input wire rx_done_o,
    input wire rx_drop_o,
    input wire rx_learn_o,
    input wire rx_mirror_o,
    input wire [2:0] rx_fwd_mask_o,
    input wire [11:0] rx_rate_bytes_o,
    input wire tx_valid_i,
    input wire tx_monitored_i,
    input wire tx_done_o,
    input wire tx_send_o,
    input wire tx_mirror_o,
    input wire tx_add_tag_o,
    input wire flow_ctrl_o,
    input wire tx_enable_o,
    input wire rx_enable_o,
    input wire sniffer_port_o,
    input wire [2:0] membership_o
);
// ============================================
// Checks
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (!reset_n_i);
sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence rx_take;
    rx_valid_i && ce_i;
endsequence
wr_resp_a: assert property (wr_take |=> ##1 s_axi_bvalid)
    else $error("write not answered");
rd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
flow_on_a: assert property (an_flow_ctrl_i |-> flow_ctrl_o)
    else $error("flow control lost");
rx_off_a: assert property (rx_take ##0 !rx_enable_o |=> rx_drop_o)
    else $error("frame kept while receive off");
fwd_mem_a: assert property (rx_take |=>
    (rx_fwd_mask_o & ~$past(membership_o)) == 3'b000)
    else $error("forward outside membership");
drop_quiet_a: assert property (rx_done_o && rx_drop_o |->
    rx_fwd_mask_o == 3'b000 && !rx_learn_o && !rx_mirror_o)
    else $error("dropped frame acted on");
rate_bytes_a: assert property (rx_take |=>
    (rx_rate_bytes_o - {1'b0, $past(rx_len_i)})
    inside {12'd0, 12'd8, 12'd12, 12'd20})
    else $error("rate byte count wrong");
tx_off_a: assert property (tx_valid_i && ce_i && !tx_enable_o
    |=> tx_done_o && !tx_send_o)
    else $error("sent while transmit off");
mon_copy_a: assert property (tx_valid_i && ce_i && tx_monitored_i
    && !sniffer_port_o |=> !tx_send_o)
    else $error("monitored copy sent");
tx_mark_a: assert property (tx_mirror_o || tx_add_tag_o |-> tx_send_o)
    else $error("mark without send");
endmodule // spcr_port_chk

// >>> spcr_port_regs.v
// Purpose: Port control register bank with AXI4-Lite slave
// Assumes: Engine descriptors arrive on the switch clock
// Notes: Clock enable low freezes every flip-flop
`timescale 1ns/1ps
`include "spcr_consts.vh"
module spcr_port_regs #(
    parameter AW = 12
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    output wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    input wire an_flow_ctrl_i,
    input wire rx_valid_i,
    input wire rx_tagged_i,
    input wire [11:0] rx_vid_i,
    input wire [2:0] rx_prio_i,
    input wire [2:0] rx_vlan_members_i,
    input wire [2:0] rx_dest_mask_i,
    input wire rx_bcast_i,
    input wire rx_mcast_i,
    input wire rx_flood_i,
    input wire [10:0] rx_len_i,
    output wire rx_done_o,
    output wire rx_drop_o,
    output wire rx_learn_o,
    output wire rx_mirror_o,
    output wire rx_rate_count_o,
    output wire [11:0] rx_vid_o,
    output wire [2:0] rx_prio_o,
    output wire [2:0] rx_fwd_mask_o,
    output wire [11:0] rx_rate_bytes_o,
    input wire tx_valid_i,
    input wire tx_untagged_i,
    input wire tx_insert_i,
    input wire tx_monitored_i,
    input wire [10:0] tx_len_i,
    output reg tx_done_o,
    output reg tx_send_o,
    output reg tx_mirror_o,
    output reg tx_add_tag_o,
    output reg [11:0] tx_rate_bytes_o,
    output wire [15:0] port_default_tag_o,
    output wire flow_ctrl_o,
    output wire back_pressure_o,
    output wire tx_enable_o,
    output wire rx_enable_o,
    output wire sniffer_port_o,
    output wire [2:0] membership_o,
    output wire [1:0] limit_mode_o
);
    // ======================================
    // Address decode
    wire [15:0] ctrl2;
    wire [15:0] dtag;
    wire [15:0] ctrl3;
    localparam [AW-1:0] A_CTRL2 = {`SPCR_IDX_CTRL2, 2'b00};
    localparam [AW-1:0] A_DTAG = {`SPCR_IDX_DTAG, 2'b00};
    localparam [AW-1:0] A_CTRL3 = {`SPCR_IDX_CTRL3, 2'b00};
    localparam [AW-1:0] A_STAT = `SPCR_ADDR_STAT;

    // ======================================
    // Write channel
    reg aw_full_q;
    reg w_full_q;
    reg [AW-1:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    wire [AW-1:0] wa = {waddr_q[AW-1:2], 2'b00};
    wire wr_go = aw_full_q && w_full_q && !bvalid_q;
    wire wr_ctrl2 = wr_go && (wa == A_CTRL2);
    wire wr_dtag = wr_go && (wa == A_DTAG);
    wire wr_ctrl3 = wr_go && (wa == A_CTRL3);
    wire wr_hit = wr_ctrl2 || wr_dtag || wr_ctrl3 || (wa == A_STAT);

    assign s_axi_awready = ce_i && !aw_full_q && !bvalid_q;
    assign s_axi_wready = ce_i && !w_full_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            waddr_q <= {AW{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `SPCR_RESP_OK;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `SPCR_RESP_OK : `SPCR_RESP_ERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ======================================
    // Registers
    spcr_field #(
        .RST(`SPCR_CTRL2_RST),
        .MASK(`SPCR_CTRL2_MASK)
    ) u_ctrl2 (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .wr_i(wr_ctrl2),
        .wdata_i(wdata_q[15:0]),
        .wstrb_i(wstrb_q[1:0]),
        .q_o(ctrl2)
    );

    spcr_field #(
        .RST(`SPCR_DTAG_RST),
        .MASK(`SPCR_DTAG_MASK)
    ) u_dtag (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .wr_i(wr_dtag),
        .wdata_i(wdata_q[15:0]),
        .wstrb_i(wstrb_q[1:0]),
        .q_o(dtag)
    );

    spcr_field #(
        .RST(`SPCR_CTRL3_RST),
        .MASK(`SPCR_CTRL3_MASK)
    ) u_ctrl3 (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .wr_i(wr_ctrl3),
        .wdata_i(wdata_q[15:0]),
        .wstrb_i(wstrb_q[1:0]),
        .q_o(ctrl3)
    );

    // ======================================
    // Ingress decisions
    spcr_rx_eval u_rx (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .ctrl2_i(ctrl2),
        .dtag_i(dtag),
        .ctrl3_i(ctrl3),
        .valid_i(rx_valid_i),
        .tagged_i(rx_tagged_i),
        .vid_i(rx_vid_i),
        .prio_i(rx_prio_i),
        .vmem_i(rx_vlan_members_i),
        .dest_i(rx_dest_mask_i),
        .bcast_i(rx_bcast_i),
        .mcast_i(rx_mcast_i),
        .flood_i(rx_flood_i),
        .len_i(rx_len_i),
        .done_o(rx_done_o),
        .drop_o(rx_drop_o),
        .learn_o(rx_learn_o),
        .mirror_o(rx_mirror_o),
        .count_o(rx_rate_count_o),
        .vid_o(rx_vid_o),
        .prio_o(rx_prio_o),
        .fwd_o(rx_fwd_mask_o),
        .bytes_o(rx_rate_bytes_o)
    );

    // ======================================
    // Egress decisions
    wire tx_en = ctrl2[`SPCR_B_TXEN];
    wire sniffer = ctrl2[`SPCR_B_SNIFP];
    wire [11:0] tx_ifg = ctrl3[`SPCR_B_IFG] ? `SPCR_IFG_BYTES : 12'h000;
    wire [11:0] tx_pre = ctrl3[`SPCR_B_PRE] ? `SPCR_PRE_BYTES : 12'h000;
    wire [11:0] tx_bytes = {1'b0, tx_len_i} + tx_ifg + tx_pre;
    wire tx_pass = tx_en && (!tx_monitored_i || sniffer);

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_done_o <= 1'b0;
            tx_send_o <= 1'b0;
            tx_mirror_o <= 1'b0;
            tx_add_tag_o <= 1'b0;
            tx_rate_bytes_o <= 12'h000;
        end else if (ce_i) begin
            tx_done_o <= tx_valid_i;
            if (tx_valid_i) begin
                tx_send_o <= tx_pass;
                tx_mirror_o <= tx_pass && ctrl2[`SPCR_B_TXSN];
                tx_add_tag_o <= tx_pass && tx_untagged_i && tx_insert_i;
                tx_rate_bytes_o <= tx_bytes;
            end
        end
    end

    // ======================================
    // Drop counter status
    reg [15:0] drop_cnt_q;
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drop_cnt_q <= 16'h0000;
        end else if (ce_i) begin
            if (rx_done_o && rx_drop_o && drop_cnt_q != 16'hffff) begin
                drop_cnt_q <= drop_cnt_q + 16'h0001;
            end
        end
    end

    // ======================================
    // Read channel
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    reg [31:0] rd_d;
    reg rd_hit;
    wire [AW-1:0] ra = {s_axi_araddr[AW-1:2], 2'b00};

    assign s_axi_arready = ce_i && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always @* begin
        rd_d = 32'h00000000;
        rd_hit = 1'b1;
        case (ra)
            A_CTRL2: rd_d = {16'h0000, ctrl2};
            A_DTAG: rd_d = {16'h0000, dtag};
            A_CTRL3: rd_d = {16'h0000, ctrl3};
            A_STAT: rd_d = {16'h0000, drop_cnt_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `SPCR_RESP_OK;
        end else if (ce_i) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_d;
                rresp_q <= rd_hit ? `SPCR_RESP_OK : `SPCR_RESP_ERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ======================================
    // Configuration outputs
    assign port_default_tag_o = dtag;
    assign flow_ctrl_o = ctrl2[`SPCR_B_FFC] || an_flow_ctrl_i;
    assign back_pressure_o = ctrl2[`SPCR_B_BP];
    assign tx_enable_o = tx_en;
    assign rx_enable_o = ctrl2[`SPCR_B_RXEN];
    assign sniffer_port_o = sniffer;
    assign membership_o = ctrl2[2:0];
    assign limit_mode_o = ctrl3[3:2];
endmodule // spcr_port_regs

// >>> spcr_rx_eval.v
// Purpose: Per-frame ingress decision from port configuration
// Assumes: Frame descriptor is one-cycle pulse on switch clock
// Notes: Results appear one cycle after the descriptor
`timescale 1ns/1ps
`include "spcr_consts.vh"
module spcr_rx_eval (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire [15:0] ctrl2_i,
    input wire [15:0] dtag_i,
    input wire [15:0] ctrl3_i,
    input wire valid_i,
    input wire tagged_i,
    input wire [11:0] vid_i,
    input wire [2:0] prio_i,
    input wire [2:0] vmem_i,
    input wire [2:0] dest_i,
    input wire bcast_i,
    input wire mcast_i,
    input wire flood_i,
    input wire [10:0] len_i,
    output reg done_o,
    output reg drop_o,
    output reg learn_o,
    output reg mirror_o,
    output reg count_o,
    output reg [11:0] vid_o,
    output reg [2:0] prio_o,
    output reg [2:0] fwd_o,
    output reg [11:0] bytes_o
);
    // ======================================
    // Decision terms
    wire [11:0] port_default_vlan_id = dtag_i[11:0];
    wire [2:0] upri = dtag_i[15:13];
    wire use_def = !tagged_i || (vid_i == 12'h000);
    wire [11:0] evid = use_def ? port_default_vlan_id : vid_i;
    wire [2:0] fpri = tagged_i ? prio_i : upri;
    wire ceil = ctrl2_i[`SPCR_B_CEIL] && (fpri > upri);
    wire vf = ctrl2_i[`SPCR_B_VFILT] && !vmem_i[0];
    wire np = ctrl2_i[`SPCR_B_NPVID] && (evid != port_default_vlan_id);
    wire drop = !ctrl2_i[`SPCR_B_RXEN] || vf || np;
    reg cnt;
    always @* begin
        case (ctrl3_i[3:2])
            `SPCR_M_ALL: cnt = 1'b1;
            `SPCR_M_BMF: cnt = bcast_i || mcast_i || flood_i;
            `SPCR_M_BM: cnt = bcast_i || mcast_i;
            default: cnt = bcast_i;
        endcase
    end
    wire [11:0] ifg = ctrl3_i[`SPCR_B_IFG] ? `SPCR_IFG_BYTES : 12'h000;
    wire [11:0] pre = ctrl3_i[`SPCR_B_PRE] ? `SPCR_PRE_BYTES : 12'h000;
    wire [11:0] bytes = {1'b0, len_i} + ifg + pre;
    // ======================================
    // Result registers
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
            drop_o <= 1'b0;
            learn_o <= 1'b0;
            mirror_o <= 1'b0;
            count_o <= 1'b0;
            vid_o <= 12'h000;
            prio_o <= 3'h0;
            fwd_o <= 3'h0;
            bytes_o <= 12'h000;
        end else if (ce_i) begin
            done_o <= valid_i;
            if (valid_i) begin
                drop_o <= drop;
                learn_o <= !drop && !ctrl2_i[`SPCR_B_LDIS];
                mirror_o <= !drop && ctrl2_i[`SPCR_B_RXSN];
                count_o <= cnt;
                vid_o <= evid;
                prio_o <= ceil ? upri : fpri;
                fwd_o <= drop ? 3'h0 : (dest_i & ctrl2_i[2:0]);
                bytes_o <= bytes;
            end
        end
    end
endmodule // spcr_rx_eval

// >>> tb_spcr_port_regs.sv
// Purpose: Self-checking bench for the port control bank
// Assumes: Clock enable held high
// Notes: Random register values and frame descriptors
`timescale 1ns/1ps
`include "spcr_consts.vh"
module tb_spcr_port_regs;
logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
logic an = 0, rxv = 0, rxt = 0, rxb = 0, rxm = 0, rxf = 0;
logic txv = 0, txu = 0, txi = 0, txm = 0;
logic [11:0] awa = 0, ara = 0, rxid = 0;
logic [31:0] wd = 0, r;
logic [3:0] ws = 0;
logic [2:0] rxp = 0, rxvm = 0, rxd = 0;
logic [10:0] rxl = 0, txl = 0;
logic [15:0] m [0:2];
logic [15:0] nd = 0;
wire awr, wrd, bv, arr, rv, rdn, rdr, rle, rmi, rco, tdn, tse, tmi, tad;
wire fc, bp, ten, ren, snf;
wire [1:0] br, rr, lm;
wire [31:0] rd;
wire [11:0] rvid, rby, tby;
wire [2:0] rpr, rfw, mem;
wire [15:0] ptag;
int fails = 0, tests_run = 0, i, k;
always #10 clk = ~clk;
spcr_port_regs spcr_port_regs_i (.sys_clk_i(clk), .reset_n_i(rst_n),
    .ce_i(1'b1), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'b000), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'b000), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .an_flow_ctrl_i(an),
    .rx_valid_i(rxv), .rx_tagged_i(rxt), .rx_vid_i(rxid), .rx_prio_i(rxp),
    .rx_vlan_members_i(rxvm), .rx_dest_mask_i(rxd), .rx_bcast_i(rxb),
    .rx_mcast_i(rxm), .rx_flood_i(rxf), .rx_len_i(rxl),
    .rx_done_o(rdn), .rx_drop_o(rdr), .rx_learn_o(rle), .rx_mirror_o(rmi),
    .rx_rate_count_o(rco), .rx_vid_o(rvid), .rx_prio_o(rpr),
    .rx_fwd_mask_o(rfw), .rx_rate_bytes_o(rby), .tx_valid_i(txv),
    .tx_untagged_i(txu), .tx_insert_i(txi), .tx_monitored_i(txm),
    .tx_len_i(txl), .tx_done_o(tdn), .tx_send_o(tse), .tx_mirror_o(tmi),
    .tx_add_tag_o(tad), .tx_rate_bytes_o(tby), .port_default_tag_o(ptag),
    .flow_ctrl_o(fc), .back_pressure_o(bp), .tx_enable_o(ten),
    .rx_enable_o(ren), .sniffer_port_o(snf), .membership_o(mem),
    .limit_mode_o(lm));
// ============================================
// Reporting and bus tasks
task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task cmp(input logic [47:0] g, input logic [47:0] e);
    tests_run++;
    if (g !== e) begin
        fails++;
        $display("mismatch %0t got %h exp %h", $time, g, e);
    end
endtask
task hang;
    fails++;
    $display("mismatch %0t bus wait ran out", $time);
    stop_test;
endtask
task wr(input [11:0] a, input [15:0] d, input [1:0] s, input [1:0] er);
    logic ga, gw, ok;
    int n;
    ok = 0;
    awv <= 1; wv <= 1; awa <= a; wd <= {16'hffff, d};
    ws <= {2'b11, s}; bre <= 1;
    for (n = 0; n < 50 && !ok; n++) begin
        @(negedge clk);
        ga = awv && awr; gw = wv && wrd; ok = bv;
        if (ok) cmp({46'h0, br}, {46'h0, er});
        @(posedge clk);
        if (ga) awv <= 0;
        if (gw) wv <= 0;
        if (ok) bre <= 0;
    end
    if (!ok) hang;
    @(posedge clk);
endtask
task chkrd(input [11:0] a, input [31:0] e, input [1:0] er);
    logic g, ok;
    logic [33:0] v;
    int n;
    ok = 0;
    arv <= 1; ara <= a; rre <= 1;
    for (n = 0; n < 50 && !ok; n++) begin
        @(negedge clk);
        g = arv && arr; ok = rv; v = {rr, rd};
        @(posedge clk);
        if (g) arv <= 0;
        if (ok) rre <= 0;
    end
    if (!ok) hang;
    @(posedge clk);
    cmp({14'h0, v}, {14'h0, er, e});
endtask
// ============================================
// Expectations
function [11:0] by(input [10:0] l);
    by = {1'b0, l} + (m[2][1] ? 12'd12 : 12'd0) + (m[2][0] ? 12'd8 : 12'd0);
endfunction
function [33:0] erx;
    logic [11:0] v;
    logic [2:0] p, u;
    logic dr, cn;
    u = m[1][15:13];
    v = (!rxt || rxid == 12'h0) ? m[1][11:0] : rxid;
    p = rxt ? rxp : u;
    if (m[0][3] && p > u) p = u;
    dr = !m[0][9] || (m[0][14] && !rxvm[0]) || (m[0][13] && v != m[1][11:0]);
    case (m[2][3:2])
        2'b00: cn = 1;
        2'b01: cn = rxb | rxm | rxf;
        2'b10: cn = rxb | rxm;
        default: cn = rxb;
    endcase
    erx = {dr, !dr & !m[0][8], !dr & m[0][6], cn, v, p,
        dr ? 3'b000 : rxd & m[0][2:0], by(rxl)};
endfunction
function [14:0] etx;
    logic s;
    s = m[0][10] & (!txm | m[0][7]);
    etx = {s, s & m[0][5], s & txu & txi, by(txl)};
endfunction
task desc;
    r = $urandom;
    {rxt, rxp, rxvm, rxd, rxb, rxm, rxf, rxl} <= r[23:0];
    rxid <= r[24] ? m[1][11:0] : {10'h0, r[26:25]};
    {txu, txi, txm, txl, an} <= 15'($urandom);
    rxv <= 1; txv <= 1;
    @(posedge clk);
    rxv <= 0; txv <= 0;
    @(negedge clk);
    cmp({46'h0, rdn, tdn}, 48'h3);
    cmp({rdr, rle, rmi, rco, rvid, rpr, rfw, rby}, erx());
    cmp({tse, tmi, tad, tby}, etx());
    cmp(fc, m[0][12] | an);
    if (erx() >> 33) nd = nd + 16'h1;
    @(posedge clk);
endtask
task wk(input int q, input [15:0] d, input [1:0] s);
    logic [15:0] mk;
    mk = q == 0 ? `SPCR_CTRL2_MASK : q == 1 ? `SPCR_DTAG_MASK : `SPCR_CTRL3_MASK;
    wr(12'h1b8 + 12'(8 * q), d, s, 2'b00);
    m[q] = ((s[0] ? d : m[q]) & 16'h00ff | (s[1] ? d : m[q]) & 16'hff00) & mk;
    chkrd(12'h1b8 + 12'(8 * q), {16'h0, m[q]}, 2'b00);
    cmp({ptag, bp, ten, ren, snf, mem, lm}, {m[1], m[0][11], m[0][10],
        m[0][9], m[0][7], m[0][2:0], m[2][3:2]});
    repeat (4) desc();
endtask
// ============================================
// Main sequence
initial begin
    void'($urandom(62466));
    m[0] = 16'h0607; m[1] = 16'h0001; m[2] = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chkrd(12'h1b8, 32'h0607, 2'b00);
    chkrd(12'h1c0, 32'h0001, 2'b00);
    chkrd(12'h1c8, 32'h0000, 2'b00);
    chkrd(12'h1bc, 32'h0000, 2'b10);
    wr(12'h1bc, 16'hffff, 2'b11, 2'b10);
    wr(12'h3c0, 16'h1234, 2'b11, 2'b00);
    repeat (4) desc();
    wk(0, 16'hffff, 2'b11);
    wk(2, 16'hffff, 2'b11);
    wk(1, 16'hf000, 2'b11);
    for (i = 0; i < 40; i++) begin
        k = $urandom % 3;
        r = $urandom;
        wk(k, r[15:0], r[17:16]);
    end
    chkrd(12'h3c0, {16'h0, nd}, 2'b00);
    stop_test;
end
endmodule // tb_spcr_port_regs
bind spcr_port_regs spcr_port_chk spcr_port_chk_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .an_flow_ctrl_i(an_flow_ctrl_i),
    .rx_valid_i(rx_valid_i), .rx_len_i(rx_len_i), .rx_done_o(rx_done_o),
    .rx_drop_o(rx_drop_o), .rx_learn_o(rx_learn_o),
    .rx_mirror_o(rx_mirror_o), .rx_fwd_mask_o(rx_fwd_mask_o),
    .rx_rate_bytes_o(rx_rate_bytes_o), .tx_valid_i(tx_valid_i),
    .tx_monitored_i(tx_monitored_i), .tx_done_o(tx_done_o),
    .tx_send_o(tx_send_o), .tx_mirror_o(tx_mirror_o),
    .tx_add_tag_o(tx_add_tag_o), .flow_ctrl_o(flow_ctrl_o),
    .tx_enable_o(tx_enable_o), .rx_enable_o(rx_enable_o),
    .sniffer_port_o(sniffer_port_o), .membership_o(membership_o));
